//--- verilog/usart_defines.svh
// Register offsets, field positions, reset values and counts for the USART
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH
`define OFF_CTRL    12'h000
`define OFF_BAUD_LO 12'h004
`define OFF_BAUD_HI 12'h008
`define OFF_DATA    12'h00c
`define OFF_STAT    12'h010
`define CTRL_RST    12'h061
`define CTL_PRR     0
`define CTL_SYNC    1
`define CTL_DS      2
`define CTL_DIR     3
`define CTL_POL     4
`define CTL_CSZ     7:5
`define CTL_PM      9:8
`define CTL_SBS     10
`define CTL_TX9     11
`define CTRL_W      12
`define BAUD_LO_W   8
`define BAUD_HI_W   4
`define CSZ_NINE    3'h7
`define BITS_MIN    4'h5
`define BITS_DEF    4'h8
`define BITS_NINE   4'h9
`define DIV_NORM    4'hf
`define DIV_DBL     4'h7
`define HALF_NORM   4'h7
`define HALF_DBL    4'h3
`endif

//--- verilog/usart_pkg.sv
// Types shared by the USART modules
package usart_pkg;
   typedef enum logic [2:0] {
      FS_IDLE   = 3'h0,
      FS_START  = 3'h1,
      FS_DATA   = 3'h3,
      FS_PARITY = 3'h2,
      FS_STOP   = 3'h6
   } frame_state_t;
   typedef struct packed {
      logic       fe;
      logic       pe;
      logic [8:0] data;
   } rx_word_t;
endpackage

//--- verilog/baud_if.sv
// Link between the USART core and its baud rate generator
`timescale 1ns/1ps
`default_nettype none
interface baud_if #(parameter int W = 12);
   logic [W-1:0] divisor;
   logic         reload;
   logic         run;
   logic         tick;
   modport gen  (input divisor, reload, run, output tick);
   modport user (output divisor, reload, run, input tick);
endinterface
`default_nettype wire

//--- verilog/baud_gen.sv
// Baud rate down-counter
`timescale 1ns/1ps
`default_nettype none
module baud_gen #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_i,
   // Divisor and tick
   baud_if.gen       bus
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (!bus.run || bus.reload || cnt_reg == '0) begin
         cnt_reg <= bus.divisor;
      end else begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign bus.tick = bus.run && !bus.reload && cnt_reg == '0;

   a_tick_reloads:
   assert property (@(posedge clock_i) disable iff (rst_i)
      bus.tick |=> cnt_reg == $past(bus.divisor))
   else $error("counter not reloaded after tick");
   a_low_write_reload:
   assert property (@(posedge clock_i) disable iff (rst_i)
      bus.reload |-> !bus.tick ##1 cnt_reg == $past(bus.divisor))
   else $error("low byte write did not reload counter");
endmodule
`default_nettype wire

//--- verilog/xck_sync.sv
// Synchroniser and edge detector for the external transfer clock
`timescale 1ns/1ps
`default_nettype none
module xck_sync (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_i,
   // Pin in, edges out
   input  wire logic pin_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_o = sync_reg && !last_reg;
   assign fall_o = !sync_reg && last_reg;

   a_edge_latency:
   assert property (@(posedge clock_i) disable iff (rst_i)
      rise_o |-> $past(pin_i, 2) && !$past(pin_i, 3))
   else $error("rising edge not two cycles behind pin");
endmodule
`default_nettype wire

//--- verilog/usart_clkfmt.sv
// USART clock generation, frame formatting and APB registers
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.svh"
// What this block does
// - Four clock modes; one bit picks asynchronous or synchronous
// - In synchronous mode clock direction picks master or slave
// - Transfer clock pin used only in synchronous mode, else not driven
// - Baud counter reloads at zero and on low divisor byte write
// - One baud tick each time the counter reaches zero, except in a cycle that writes the low divisor byte
// - Transmitter divides ticks by 16, 8 or 2 depending on mode
// - Baud divisor is 12 bits over high and low bytes
// - Double speed cuts asynchronous divider and samples from 16 to 8
// - Slave clock is synchronised then edge detected, two cycle delay
// - Receive sampling uses the edge opposite to transmit change
// - Polarity 0 changes on rising, samples falling; 1 the reverse
// - Start bit, 5 to 9 data bits, optional parity, 1 or 2 stops
// - Data go least significant first; parity follows the last data bit
// - After stop bits next frame follows at once or line idles high
// - Character size, parity mode and stop select fields set format
// - Receiver checks only first stop bit; low stop flags framing error
// - Transmitter and receiver share one frame format setting
// - Single transmit buffer ahead of shifter allows gapless frames
// - Receiver has parity check, two entry buffer and overrun detect
// - Even parity is xor of data bits; odd parity its inverse
// - Size code 7 means nine bits; ninth comes from a control bit
module usart_clkfmt #(
   parameter int BAUD_W   = 12,
   parameter int RX_DEPTH = 2
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Serial data lines
   input  wire logic        serial_in_i,
   output logic             serial_out_o,
   // Transfer clock pin
   input  wire logic        transfer_clock_pin_i,
   output logic             transfer_clock_pin_o,
   output logic             transfer_clock_pin_oe_o
);
   import usart_pkg::*;

   localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

   logic [`CTRL_W-1:0]    ctrl_reg;
   logic [`BAUD_LO_W-1:0] baud_lo_reg;
   logic [`BAUD_HI_W-1:0] baud_hi_reg;
   logic [31:0]           prdata_reg;
   logic [31:0]           rdata;
   logic                  pslverr_reg;
   logic                  wr;
   logic                  rd;
   logic                  setup;
   logic                  mapped;
   logic                  prr;
   logic                  en;
   logic                  sync;
   logic                  ds;
   logic                  master;
   logic                  slave;
   logic                  pol;
   logic                  par_en;
   logic                  par_odd;
   logic [3:0]            nbits;
   logic [8:0]            dmask;
   logic                  tick;
   logic                  xck_reg;
   logic                  x_rise;
   logic                  x_fall;
   logic                  rise;
   logic                  fall;
   logic                  chg_edge;
   logic                  smp_edge;
   logic [3:0]            div_last;
   logic [3:0]            tx_div_reg;
   logic                  tx_bit_en;
   logic                  txb_full_reg;
   logic [8:0]            txb_data_reg;
   frame_state_t          tx_state_reg;
   logic [8:0]            tx_sh_reg;
   logic [3:0]            tx_cnt_reg;
   logic                  tx_stop2_reg;
   logic                  tx_par_reg;
   logic                  txo_reg;
   logic                  stop_done;
   logic                  tx_load;
   frame_state_t          rx_state_reg;
   logic [3:0]            rx_os_reg;
   logic [3:0]            os_last;
   logic                  rx_sample;
   logic [8:0]            rx_sh_reg;
   logic [3:0]            rx_cnt_reg;
   logic                  rx_pe_reg;
   logic                  rx_push;
   logic                  rx_pop;
   rx_word_t              rx_mem [RX_DEPTH];
   logic [PW-1:0]         rx_wp_reg;
   logic [PW-1:0]         rx_rp_reg;
   logic [PW:0]           rx_count_reg;
   logic                  rx_full;
   logic                  overrun_reg;
   rx_word_t              rx_head;

   function automatic logic [3:0] data_bits(input logic [2:0] c);
      if (c == `CSZ_NINE) begin
         return `BITS_NINE;
      end else if (c[2]) begin
         return `BITS_DEF;
      end
      return `BITS_MIN + {2'h0, c[1:0]};
   endfunction

   // Register bus: data sampled in setup, effects at access
   assign setup  = psel_i && !penable_i;
   assign wr     = psel_i && penable_i && pwrite_i;
   assign rd     = psel_i && penable_i && !pwrite_i;
   assign mapped = paddr_i == `OFF_CTRL || paddr_i == `OFF_BAUD_LO ||
                   paddr_i == `OFF_BAUD_HI || paddr_i == `OFF_DATA ||
                   paddr_i == `OFF_STAT;
   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_reg;
   assign pslverr_o = pslverr_reg;

   always_comb begin
      case (paddr_i)
         `OFF_CTRL:    rdata = {20'h0, ctrl_reg};
         `OFF_BAUD_LO: rdata = {24'h0, baud_lo_reg};
         `OFF_BAUD_HI: rdata = {28'h0, baud_hi_reg};
         `OFF_DATA:    rdata = {23'h0, rx_head.data};
         `OFF_STAT:    rdata = {26'h0, overrun_reg, rx_head.pe,
                                rx_head.fe, rx_count_reg != '0,
                                tx_state_reg == FS_IDLE, !txb_full_reg};
         default:      rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg  <= pwrite_i ? 32'h0 : rdata;
         pslverr_reg <= !mapped;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg    <= `CTRL_RST;
         baud_lo_reg <= '0;
         baud_hi_reg <= '0;
      end else if (wr) begin
         if (paddr_i == `OFF_CTRL) begin
            ctrl_reg <= pwdata_i[`CTRL_W-1:0];
         end
         if (paddr_i == `OFF_BAUD_LO) begin
            baud_lo_reg <= pwdata_i[`BAUD_LO_W-1:0];
         end
         if (paddr_i == `OFF_BAUD_HI) begin
            baud_hi_reg <= pwdata_i[`BAUD_HI_W-1:0];
         end
      end
   end

   // Mode and format decode, one setting for both directions
   assign prr     = ctrl_reg[`CTL_PRR];
   assign en      = !prr;
   assign sync    = ctrl_reg[`CTL_SYNC];
   assign master  = sync && ctrl_reg[`CTL_DIR];
   assign slave   = sync && !ctrl_reg[`CTL_DIR];
   assign ds      = ctrl_reg[`CTL_DS] && !sync;
   assign pol     = ctrl_reg[`CTL_POL];
   assign {par_en, par_odd} = ctrl_reg[`CTL_PM];
   assign nbits   = data_bits(ctrl_reg[`CTL_CSZ]);
   assign dmask   = (9'h001 << nbits) - 9'h001;

   baud_if #(.W(BAUD_W)) baud ();
   // A low byte write loads its new value, not the stale register
   assign baud.divisor = {baud_hi_reg, baud.reload
                                       ? pwdata_i[`BAUD_LO_W-1:0]
                                       : baud_lo_reg};
   assign baud.reload  = wr && paddr_i == `OFF_BAUD_LO;
   assign baud.run     = en;
   assign tick         = baud.tick;

   baud_gen #(.W(BAUD_W)) u_baud (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .bus     (baud.gen)
   );

   xck_sync u_xck (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .pin_i   (transfer_clock_pin_i),
      .rise_o  (x_rise),
      .fall_o  (x_fall)
   );

   // Master clock toggles on every tick: bit rate is tick rate over 2
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         xck_reg <= 1'b0;
      end else if (!(en && master)) begin
         xck_reg <= 1'b0;
      end else if (tick) begin
         xck_reg <= !xck_reg;
      end
   end

   assign transfer_clock_pin_o    = xck_reg;
   assign transfer_clock_pin_oe_o = en && master;
   assign rise = (master && tick && !xck_reg) || (slave && x_rise);
   assign fall = (master && tick && xck_reg) || (slave && x_fall);
   assign chg_edge = pol ? fall : rise;
   assign smp_edge = pol ? rise : fall;

   // Asynchronous bit divider
   assign div_last = ds ? `DIV_DBL : `DIV_NORM;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tx_div_reg <= '0;
      end else if (!en || sync) begin
         tx_div_reg <= '0;
      end else if (tick) begin
         tx_div_reg <= (tx_div_reg == div_last) ? 4'h0
                                                 : tx_div_reg + 4'h1;
      end
   end

   assign tx_bit_en = en && (sync ? chg_edge
                                  : tick && tx_div_reg == div_last);

   // Transmit buffer
   assign stop_done = !ctrl_reg[`CTL_SBS] || tx_stop2_reg;
   assign tx_load = tx_bit_en && txb_full_reg &&
                    (tx_state_reg == FS_IDLE ||
                     (tx_state_reg == FS_STOP && stop_done));
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         txb_full_reg <= 1'b0;
         txb_data_reg <= '0;
      end else if (tx_load) begin
         txb_full_reg <= 1'b0;
      end else if (wr && paddr_i == `OFF_DATA && !txb_full_reg) begin
         txb_full_reg <= 1'b1;
         txb_data_reg <= {ctrl_reg[`CTL_TX9], pwdata_i[7:0]};
      end
   end

   // Transmit frame sequencer
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_reg <= FS_IDLE;
         tx_sh_reg    <= '0;
         tx_cnt_reg   <= '0;
         tx_stop2_reg <= 1'b0;
         tx_par_reg   <= 1'b0;
         txo_reg      <= 1'b1;
      end else if (!en) begin
         tx_state_reg <= FS_IDLE;
         tx_stop2_reg <= 1'b0;
         txo_reg      <= 1'b1;
      end else if (tx_load) begin
         tx_state_reg <= FS_START;
         tx_sh_reg    <= txb_data_reg & dmask;
         tx_par_reg   <= ^(txb_data_reg & dmask) ^ par_odd;
         tx_stop2_reg <= 1'b0;
         txo_reg      <= 1'b0;
      end else if (tx_bit_en) begin
         case (tx_state_reg)
            FS_START: begin
               tx_state_reg <= FS_DATA;
               tx_cnt_reg   <= '0;
               txo_reg      <= tx_sh_reg[0];
            end
            FS_DATA: begin
               if (tx_cnt_reg == nbits - 4'h1) begin
                  tx_state_reg <= par_en ? FS_PARITY : FS_STOP;
                  txo_reg      <= par_en ? tx_par_reg : 1'b1;
               end else begin
                  tx_sh_reg  <= tx_sh_reg >> 1;
                  tx_cnt_reg <= tx_cnt_reg + 4'h1;
                  txo_reg    <= tx_sh_reg[1];
               end
            end
            FS_PARITY: begin
               tx_state_reg <= FS_STOP;
               txo_reg      <= 1'b1;
            end
            FS_STOP: begin
               if (!stop_done) begin
                  tx_stop2_reg <= 1'b1;
               end else begin
                  tx_state_reg <= FS_IDLE;
               end
            end
            default: begin
               tx_state_reg <= FS_IDLE;
               txo_reg      <= 1'b1;
            end
         endcase
      end
   end

   assign serial_out_o = txo_reg;

   // Receive recovery: half a bit to confirm start, then a full bit
   assign os_last = (rx_state_reg == FS_IDLE)
                  ? (ds ? `HALF_DBL : `HALF_NORM) : div_last;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rx_os_reg <= '0;
      end else if (!en || sync) begin
         rx_os_reg <= '0;
      end else if (tick) begin
         if ((rx_state_reg == FS_IDLE && serial_in_i) ||
             rx_os_reg == os_last) begin
            rx_os_reg <= '0;
         end else begin
            rx_os_reg <= rx_os_reg + 4'h1;
         end
      end
   end

   assign rx_sample = en && (sync ? smp_edge : tick && rx_os_reg == os_last
                     && !(rx_state_reg == FS_IDLE && serial_in_i));

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_reg <= FS_IDLE;
         rx_sh_reg    <= '0;
         rx_cnt_reg   <= '0;
         rx_pe_reg    <= 1'b0;
      end else if (!en) begin
         rx_state_reg <= FS_IDLE;
      end else if (rx_sample) begin
         case (rx_state_reg)
            FS_IDLE: begin
               if (!serial_in_i) begin
                  rx_state_reg <= FS_DATA;
                  rx_sh_reg    <= '0;
                  rx_cnt_reg   <= '0;
                  rx_pe_reg    <= 1'b0;
               end
            end
            FS_DATA: begin
               rx_sh_reg[rx_cnt_reg] <= serial_in_i;
               rx_cnt_reg <= rx_cnt_reg + 4'h1;
               if (rx_cnt_reg == nbits - 4'h1) begin
                  rx_state_reg <= par_en ? FS_PARITY : FS_STOP;
               end
            end
            FS_PARITY: begin
               rx_pe_reg    <= ^(rx_sh_reg & dmask) ^ par_odd
                               ^ serial_in_i;
               rx_state_reg <= FS_STOP;
            end
            default: begin
               rx_state_reg <= FS_IDLE;
            end
         endcase
      end
   end

   // Two entry receive buffer with overrun
   assign rx_push = rx_sample && rx_state_reg == FS_STOP;
   assign rx_full = rx_count_reg == (PW + 1)'(RX_DEPTH);
   assign rx_pop  = rd && paddr_i == `OFF_DATA && rx_count_reg != '0;
   assign rx_head = (rx_count_reg != '0) ? rx_mem[rx_rp_reg] : '0;

   always_ff @(posedge clock_i) begin
      if (rx_push && !rx_full) begin
         rx_mem[rx_wp_reg] <= '{fe: !serial_in_i, pe: rx_pe_reg,
                                data: rx_sh_reg};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rx_wp_reg    <= '0;
         rx_rp_reg    <= '0;
         rx_count_reg <= '0;
      end else begin
         if (rx_push && !rx_full) begin
            rx_wp_reg <= (rx_wp_reg == PW'(RX_DEPTH - 1)) ? '0
                                                          : rx_wp_reg + 1'b1;
         end
         if (rx_pop) begin
            rx_rp_reg <= (rx_rp_reg == PW'(RX_DEPTH - 1)) ? '0
                                                          : rx_rp_reg + 1'b1;
         end
         rx_count_reg <= rx_count_reg + (PW + 1)'(rx_push && !rx_full)
                                      - (PW + 1)'(rx_pop);
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         overrun_reg <= 1'b0;
      end else if (rx_push && rx_full) begin
         overrun_reg <= 1'b1;
      end else if (rx_pop) begin
         overrun_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   a_pin_released:
   assert property (!sync |-> !transfer_clock_pin_oe_o)
   else $error("transfer clock driven outside synchronous mode");
   a_master_drive:
   assert property (en && master |-> transfer_clock_pin_oe_o)
   else $error("master does not drive transfer clock");
   a_power_quiet:
   assert property (prr |=> serial_out_o && tx_state_reg == FS_IDLE)
   else $error("unit active while power reduced");
   a_master_toggle:
   assert property (en && master && tick |=>
      transfer_clock_pin_o != $past(transfer_clock_pin_o))
   else $error("master clock did not toggle on tick");
   a_start_low:
   assert property (tx_state_reg == FS_START |-> !serial_out_o)
   else $error("start bit not low");
   a_idle_high:
   assert property (tx_state_reg == FS_IDLE |-> serial_out_o)
   else $error("idle line not high");
   a_stop_high:
   assert property (tx_state_reg == FS_STOP |-> serial_out_o)
   else $error("stop bit not high");
   a_parity_bit:
   assert property (tx_state_reg == FS_PARITY |->
      serial_out_o == tx_par_reg)
   else $error("parity bit wrong");
   a_async_rate:
   assert property (tx_bit_en && !sync |->
      tx_div_reg == (ctrl_reg[`CTL_DS] ? `DIV_DBL : `DIV_NORM))
   else $error("asynchronous divider wrong");
   a_sync_edge:
   assert property ($past(sync) && $past(en) && $changed(tx_state_reg) |->
      $past(chg_edge))
   else $error("synchronous output changed off its edge");
   a_overrun_set:
   assert property (rx_push && rx_full |=> overrun_reg)
   else $error("overrun not flagged");

   c_frame_sent: cover property (tx_state_reg == FS_STOP ##1
                                 tx_state_reg == FS_START);
   c_rx_push:    cover property (rx_push && !rx_full);
   c_master:     cover property (en && master && tick);
   c_slave_edge: cover property (en && slave && smp_edge);
endmodule
`default_nettype wire

//--- test/remote_uart.sv
// Far side serial transceiver: sends frames and captures frames
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
   input  wire logic clock_i,
   input  wire logic line_i,
   output var  logic line_o
);
   initial line_o = 1'b1;
   // Drive n bits, lowest first, each held bt clocks
   task automatic send(input logic [12:0] f, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         line_o <= f[i];
         repeat (bt) @(posedge clock_i);
      end
      line_o <= 1'b1;
   endtask
   // Wait for a start bit, then sample each bit at its middle
   task automatic grab(input int n, input int bt, output logic [12:0] f);
      int k;
      f = '0;
      for (k = 0; k < 4000 && line_i !== 1'b0; k++) @(posedge clock_i);
      repeat (bt / 2) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         f[i] = line_i;
         repeat (bt) @(posedge clock_i);
      end
   endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the USART clock and frame block
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.svh"
module tb;
   logic clock_i, rst_i, psel_i, penable_i, pwrite_i, serial_in_i, xck;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, r;
   logic pready_o, pslverr_o, serial_out_o, xck_o, xck_oe, err;
   logic [12:0] f, g;
   int failures = 0, compares = 0, n, bt, nb;
   logic [11:0] rc[7] = '{12'h060, 12'h200, 12'h740, 12'h8e0,
                          12'h024, 12'h360, 12'h160};
   logic [8:0] rd[7] = '{9'h0a5, 9'h013, 9'h05a, 9'h1c3, 9'h02d,
                         9'h0ff, 9'h081};
   usart_clkfmt usart_clkfmt_inst (.clock_i(clock_i), .rst_i(rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
      .transfer_clock_pin_i(xck), .transfer_clock_pin_o(xck_o),
      .transfer_clock_pin_oe_o(xck_oe));
   remote_uart remote_uart_inst (.clock_i(clock_i),
      .line_i(serial_out_o), .line_o(serial_in_i));
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   task automatic summarize();
      if (failures == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      compares++;
      if (v !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      r = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
      if (k >= 50) begin
         failures++;
         summarize();
      end
   endtask
   // Build the expected frame; returns its bit count
   function automatic int mk(input logic [11:0] c, input logic [8:0] d,
                             output logic [12:0] o);
      int m;
      logic p;
      nb = c[7:5] == 3'h7 ? 9 : c[7:5] > 3 ? 8 : c[7:5] + 5;
      o = '0;
      p = c[8];
      for (int i = 0; i < nb; i++) begin
         o[1+i] = d[i];
         p ^= d[i];
      end
      m = nb + 1;
      if (c[9]) begin
         o[m] = p;
         m++;
      end
      o[m] = 1'b1;
      m++;
      if (c[10]) begin
         o[m] = 1'b1;
         m++;
      end
      return m;
   endfunction
   initial begin
      rst_i = 1'b1;
      {psel_i, penable_i, pwrite_i, xck} = '0;
      paddr_i = '0;
      pwdata_i = '0;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      apb(0, `OFF_CTRL, 0);
      chk("ctrl_reset", `CTRL_RST, r);
      repeat (40) @(posedge clock_i);
      chk("idle_line", 1, {xck_oe, serial_out_o});
      apb(0, 12'h014, 0);
      chk("unmapped_err", 1, err);
      apb(1, `OFF_BAUD_HI, 0);
      apb(1, `OFF_BAUD_LO, 1);
      for (int i = 0; i < 7; i++) begin
         n = mk(rc[i], rd[i], f);
         bt = rc[i][2] ? 16 : 32;
         apb(1, `OFF_CTRL, rc[i]);
         apb(1, `OFF_DATA, rd[i]);
         fork
            remote_uart_inst.grab(n, bt, g);
            remote_uart_inst.send(f, n, bt);
         join
         repeat (2 * bt) @(posedge clock_i);
         chk("tx_frame", f, g);
         chk("tx_oe", 0, xck_oe);
         apb(0, `OFF_STAT, 0);
         chk("rx_status", 3'h1, r[4:2]);
         apb(0, `OFF_DATA, 0);
         chk("rx_data", rd[i] & ((1 << nb) - 1), r);
      end
      n = mk(12'h460, 9'h03c, f);
      apb(1, `OFF_CTRL, 12'h460);
      for (int j = 0; j < 2; j++) begin
         g = f;
         g[10-j] = 1'b0;
         remote_uart_inst.send(g, n, 32);
         // A low stop bit can pass for a new start; drain that frame too
         repeat (400) @(posedge clock_i);
         apb(0, `OFF_STAT, 0);
         chk("framing_err", j, r[3]);
         apb(0, `OFF_DATA, 0);
         apb(0, `OFF_DATA, 0);
      end
      repeat (3) begin
         remote_uart_inst.send(f, n, 32);
         @(posedge clock_i);
      end
      repeat (64) @(posedge clock_i);
      apb(0, `OFF_STAT, 0);
      chk("overrun", 1, r[5]);
      apb(1, `OFF_CTRL, 12'h06a);
      chk("master_oe", 1, xck_oe);
      apb(1, `OFF_CTRL, 12'h062);
      chk("slave_oe", 0, xck_oe);
      n = mk(12'h062, 9'h0a5, f);
      apb(1, `OFF_DATA, 9'h0a5);
      for (int i = 0; i < 24; i++) begin
         repeat (4) @(posedge clock_i);
         if (xck) g = {serial_out_o, g[12:1]};
         xck <= ~xck;
      end
      chk("slave_frame", f[9:0], g[10:1]);
      summarize();
   end
endmodule
`default_nettype wire
